/* File: verilog/cal_seq_pkg.sv */
// package for the converter mode sequencer and its host-side controller
// assumes one 125 MHz clock shared by both ends
package cal_seq_pkg;

  localparam int MODE_W = 3;
  localparam int COEF_W = 24;
  localparam int DATA_W = 24;

  typedef enum logic [2:0] {
    MODE_CONVERT   = 3'b000,
    MODE_SELF_CAL  = 3'b001,
    MODE_SYS_OFS   = 3'b010,
    MODE_SYS_PFS   = 3'b011,
    MODE_SYS_NFS   = 3'b100,
    MODE_OFS_IGAIN = 3'b101,
    MODE_SYS_GAIN  = 3'b110,
    MODE_RESERVED  = 3'b111
  } op_mode_t;

  // analog front-end routing requested by the sequencer
  typedef enum logic [1:0] {
    ROUTE_EXT     = 2'b00,
    ROUTE_SHORT   = 2'b01,
    ROUTE_REF_POS = 2'b10,
    ROUTE_REF_NEG = 2'b11
  } route_t;

  // conversion periods per step
  localparam logic [2:0] CONV_SETTLE_PERIODS = 3'h3;
  localparam logic [2:0] CAL_STEP_PERIODS = 3'h3;
  localparam logic [2:0] SYS_CAL_PERIODS = 3'h4;
  localparam logic [2:0] GAIN_TAIL_PERIODS = 3'h1;
  localparam logic [2:0] ONE_PERIOD = 3'h1;

  // default conversion period in clock cycles (scaled notch period)
  localparam int CONV_PERIOD_CYCLES_DEF = 16;

  // coefficient reset values: zero offset, unity slopes
  localparam logic [23:0] OFS_COEF_RST = 24'h000000;
  localparam logic [23:0] PFS_COEF_RST = 24'h800000;
  localparam logic [23:0] NFS_COEF_RST = 24'h800000;
  localparam logic [23:0] DATA_RST = 24'h000000;

  // host controller APB register offsets (byte addresses)
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_DATA = 12'h008;
  localparam logic [11:0] REG_OFS = 12'h00c;
  localparam logic [11:0] REG_PFS = 12'h010;
  localparam logic [11:0] REG_NFS = 12'h014;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_GAIN_LSB = 4;
  localparam int GAIN_W = 3;
  localparam logic [2:0] GAIN_ONE = 3'h0;
  // status register fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;
  localparam int STAT_MODE_LSB = 4;

endpackage

/* File: verilog/cal_seq_if.sv */
// link between the converter sequencer and its host controller
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface cal_seq_if;
  import cal_seq_pkg::*;
  logic [2:0] op_mode_select;
  logic mode_write;
  logic [2:0] input_gain_amp;
  logic data_ready_n;
  logic [23:0] result_data;
  logic [23:0] ofs_coef;
  logic [23:0] pfs_coef;
  logic [23:0] nfs_coef;

  modport device (
    input op_mode_select, mode_write, input_gain_amp,
    output data_ready_n, result_data, ofs_coef, pfs_coef, nfs_coef
  );
  modport host (
    output op_mode_select, mode_write, input_gain_amp,
    input data_ready_n, result_data, ofs_coef, pfs_coef, nfs_coef
  );
endinterface
`default_nettype wire

/* File: verilog/cal_seq_device.sv */
// converter mode sequencer: steps calibration modes in conversion periods
// assumes the modulator/filter supplies one raw result per period on sample_i
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - conversion mode: ready after three periods
// - conversion keeps coefficients, corrects with them (data path subtracts offset only)
// - self cal: short inputs, offset after three
// - then reference positive, positive coefficient after three
// - then reference reversed, negative coefficient after three
// - three more periods, then ready
// - host uses self cal only at gain one
// - system offset: store input, ready after four
// - host settles zero stimulus before offset modes (this host does not wait; settling is left to software)
// - system positive: store input, ready after four
// - system negative: store input, ready after four
// - host settles full-scale stimulus before gain modes (this host does not wait; settling is left to software)
// - combined: offset from input, positive after three
// - combined: negative after three, ready three later
// - host uses combined cal only at gain one
// - system gain: negative then reversed into positive
// - one more period after second conversion, ready
// - host never writes reserved mode code
// - three-bit mode field, code 111 reserved
module cal_seq_device
  import cal_seq_pkg::*;
#(
  parameter int CONV_PERIOD_CYCLES = CONV_PERIOD_CYCLES_DEF
) (
  input wire logic clk_i, // 125 MHz clock
  input wire logic rst_i, // synchronous reset, active high
  cal_seq_if.device link, // host link
  input wire logic [23:0] sample_i, // raw filter result for the current routing
  output logic [1:0] route_o, // analog routing request
  output logic polarity_rev_o // internal input polarity reversed
);

  initial begin
    if (CONV_PERIOD_CYCLES < 1) $error("conversion period must be at least one cycle");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OFS = 3'b001,
    ST_PFS = 3'b010,
    ST_NFS = 3'b011,
    ST_TAIL = 3'b100,
    ST_RUN = 3'b101
  } step_t;

  localparam int PCNT_W = $clog2(CONV_PERIOD_CYCLES + 1);

  // ------------------------------------------------------------
  // conversion period timebase
  // ------------------------------------------------------------
  logic [PCNT_W-1:0] pcnt_r;
  logic period_end;
  assign period_end = (pcnt_r == PCNT_W'(CONV_PERIOD_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    // realigned on mode writes so every step gets whole periods
    if (rst_i || link.mode_write || period_end) begin
      pcnt_r <= '0;
    end else begin
      pcnt_r <= pcnt_r + PCNT_W'(1);
    end
  end

  // ------------------------------------------------------------
  // step sequencer
  // ------------------------------------------------------------
  op_mode_t mode_r;
  step_t step_r;
  logic [2:0] left_r;
  logic [23:0] ofs_r, pfs_r, nfs_r, data_r;
  logic data_ready_n_n_r;
  logic [1:0] route_r;
  logic rev_r;
  logic step_done;
  assign step_done = period_end && (left_r == ONE_PERIOD);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= MODE_CONVERT;
      step_r <= ST_IDLE;
      left_r <= '0;
      route_r <= ROUTE_EXT;
      rev_r <= 1'b0;
    end else if (link.mode_write) begin
      // any write abandons the current sequence
      mode_r <= op_mode_t'(link.op_mode_select);
      rev_r <= 1'b0;
      case (op_mode_t'(link.op_mode_select))
        MODE_CONVERT: begin
          step_r <= ST_RUN;
          left_r <= CONV_SETTLE_PERIODS;
          route_r <= ROUTE_EXT;
        end
        MODE_SELF_CAL: begin
          step_r <= ST_OFS;
          left_r <= CAL_STEP_PERIODS;
          route_r <= ROUTE_SHORT;
        end
        MODE_SYS_OFS: begin
          step_r <= ST_OFS;
          left_r <= SYS_CAL_PERIODS;
          route_r <= ROUTE_EXT;
        end
        MODE_SYS_PFS: begin
          step_r <= ST_PFS;
          left_r <= SYS_CAL_PERIODS;
          route_r <= ROUTE_EXT;
        end
        MODE_SYS_NFS, MODE_SYS_GAIN: begin
          step_r <= ST_NFS;
          left_r <= SYS_CAL_PERIODS;
          route_r <= ROUTE_EXT;
        end
        MODE_OFS_IGAIN: begin
          step_r <= ST_OFS;
          left_r <= CAL_STEP_PERIODS;
          route_r <= ROUTE_EXT;
        end
        default: begin
          // reserved code: the host refuses it; should it arrive, the device just idles
          step_r <= ST_IDLE;
          left_r <= '0;
          route_r <= ROUTE_EXT;
        end
      endcase
    end else if (period_end && step_r != ST_IDLE) begin
      if (!step_done) begin
        left_r <= left_r - 3'h1;
      end else begin
        case (step_r)
          ST_OFS: begin
            if (mode_r == MODE_SELF_CAL || mode_r == MODE_OFS_IGAIN) begin
              step_r <= ST_PFS;
              left_r <= CAL_STEP_PERIODS;
              route_r <= ROUTE_REF_POS;
            end else begin
              step_r <= ST_RUN;
              left_r <= ONE_PERIOD;
            end
          end
          ST_PFS: begin
            if (mode_r == MODE_SYS_PFS) begin
              step_r <= ST_RUN;
              left_r <= ONE_PERIOD;
            end else if (mode_r == MODE_SYS_GAIN) begin
              // reversed conversion done: one plain period before ready
              step_r <= ST_TAIL;
              left_r <= GAIN_TAIL_PERIODS;
              rev_r <= 1'b0;
            end else begin
              step_r <= ST_NFS;
              left_r <= CAL_STEP_PERIODS;
              route_r <= ROUTE_REF_NEG;
            end
          end
          ST_NFS: begin
            if (mode_r == MODE_SYS_GAIN) begin
              // second conversion with input reversed internally
              step_r <= ST_PFS;
              left_r <= SYS_CAL_PERIODS;
              rev_r <= 1'b1;
            end else if (mode_r == MODE_SYS_NFS) begin
              step_r <= ST_RUN;
              left_r <= ONE_PERIOD;
            end else begin
              step_r <= ST_TAIL;
              left_r <= CAL_STEP_PERIODS;
              route_r <= ROUTE_EXT;
            end
          end
          default: begin
            step_r <= ST_RUN;
            left_r <= ONE_PERIOD;
            route_r <= ROUTE_EXT;
            rev_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // coefficients: written only at the end of their own step
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ofs_r <= OFS_COEF_RST;
      pfs_r <= PFS_COEF_RST;
      nfs_r <= NFS_COEF_RST;
    end else if (!link.mode_write && step_done) begin
      if (step_r == ST_OFS) ofs_r <= sample_i;
      if (step_r == ST_PFS) pfs_r <= sample_i;
      if (step_r == ST_NFS) nfs_r <= sample_i;
    end
  end

  // ------------------------------------------------------------
  // data-ready and output data
  // ------------------------------------------------------------
  logic finishing;
  // calibration tails end in the step that flags ready; run steps refresh data
  assign finishing = step_done && !link.mode_write &&
    ((step_r == ST_RUN) || (step_r == ST_TAIL) ||
     (step_r == ST_OFS && mode_r == MODE_SYS_OFS) ||
     (step_r == ST_PFS && mode_r == MODE_SYS_PFS) ||
     (step_r == ST_NFS && mode_r == MODE_SYS_NFS));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_ready_n_n_r <= 1'b1;
      data_r <= DATA_RST;
    end else if (link.mode_write) begin
      data_ready_n_n_r <= 1'b1;
    end else if (finishing) begin
      data_ready_n_n_r <= 1'b0;
      data_r <= sample_i - ofs_r; // corrected with stored offset
    end
  end

  assign link.data_ready_n = data_ready_n_n_r;
  assign link.result_data = data_r;
  assign link.ofs_coef = ofs_r;
  assign link.pfs_coef = pfs_r;
  assign link.nfs_coef = nfs_r;
  assign route_o = route_r;
  assign polarity_rev_o = rev_r;

endmodule
`default_nettype wire

/* File: verilog/cal_seq_host.sv */
// host controller: APB slave registers that drive the sequencer link
// assumes the device end shares clk_i
`timescale 1ns/1ps
`default_nettype none
module cal_seq_host
  import cal_seq_pkg::*;
(
  input wire logic clk_i, // 125 MHz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  cal_seq_if.host link // device link
);

  logic [2:0] mode_r, gain_r;
  logic wr_r, refused_r;
  logic [31:0] rdata_r;
  logic slverr_r;
  logic acc;
  logic [2:0] new_mode, new_gain;
  logic cal_gain1_only;
  logic bad_mode;
  assign acc = psel && !penable;
  assign new_mode = pwdata[CTRL_MODE_LSB +: MODE_W];
  assign new_gain = pwdata[CTRL_GAIN_LSB +: GAIN_W];
  // gain-one modes at any gain other than one, and the reserved code, are refused
  assign cal_gain1_only = (new_mode == MODE_SELF_CAL || new_mode == MODE_OFS_IGAIN);
  assign bad_mode = (new_mode == MODE_RESERVED) || (cal_gain1_only && new_gain != GAIN_ONE);

  // ------------------------------------------------------------
  // apb: answer in the first access cycle, registered
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= MODE_CONVERT;
      gain_r <= GAIN_ONE;
      wr_r <= 1'b0;
      refused_r <= 1'b0;
      rdata_r <= '0;
      slverr_r <= 1'b0;
      pready <= 1'b0;
    end else begin
      wr_r <= 1'b0;
      pready <= acc;
      slverr_r <= 1'b0;
      // a write lands only at the edge that completes the access
      if (psel && penable && pready && pwrite && paddr == REG_CTRL) begin
        if (bad_mode) begin
          refused_r <= 1'b1;
        end else begin
          // stimulus settling before cal modes is software's duty
          mode_r <= new_mode;
          gain_r <= new_gain;
          wr_r <= 1'b1;
          refused_r <= 1'b0;
        end
      end
      if (acc && pwrite) begin
        // refusal decided in setup so that it stands beside pready
        slverr_r <= (paddr != REG_CTRL) || bad_mode;
      end else if (acc) begin
        case (paddr)
          REG_CTRL: rdata_r <= {25'h0, gain_r, 1'b0, mode_r};
          REG_STATUS: rdata_r <= {25'h0, mode_r, 2'b00, refused_r, ~link.data_ready_n};
          REG_DATA: rdata_r <= {8'h0, link.result_data};
          REG_OFS: rdata_r <= {8'h0, link.ofs_coef};
          REG_PFS: rdata_r <= {8'h0, link.pfs_coef};
          REG_NFS: rdata_r <= {8'h0, link.nfs_coef};
          default: begin
            rdata_r <= '0;
            slverr_r <= 1'b1;
          end
        endcase
      end
    end
  end

  assign prdata = rdata_r;
  assign pslverr = slverr_r;
  assign link.op_mode_select = mode_r;
  assign link.mode_write = wr_r;
  assign link.input_gain_amp = gain_r;

endmodule
`default_nettype wire

/* File: bench/cal_seq_sva.sv */
// checker for the sequencer link: ready latency per mode, coefficient timing in self cal and system gain cal
// assumes P equals the device's CONV_PERIOD_CYCLES and one shared clock
`timescale 1ns/1ps
`default_nettype none
module cal_seq_sva
  import cal_seq_pkg::*;
#(
  parameter int P = 2
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic [2:0] op_mode_select, // mode code
  input wire logic mode_write, // mode load pulse
  input wire logic data_ready_n, // ready, active low
  input wire logic [23:0] ofs_coef, // offset coefficient
  input wire logic [23:0] pfs_coef, // positive coefficient
  input wire logic [23:0] nfs_coef // negative coefficient
);
  // ----------------------------------------------------------------
  // cycles since the last mode load
  // ----------------------------------------------------------------
  logic [15:0] cnt_r;
  logic [2:0] mode_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 16'h0000;
      mode_r <= 3'h0;
    end else if (mode_write) begin
      cnt_r <= 16'h0000;
      mode_r <= op_mode_select;
    end else if (cnt_r != 16'hffff) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_restart; mode_write |=> data_ready_n; endproperty
  a_restart: assert property (p_restart) else $error("ready stayed low after load");
  property p_conv_lat; $fell(data_ready_n) && mode_r == MODE_CONVERT |-> cnt_r == 3 * P; endproperty
  a_conv_lat: assert property (p_conv_lat) else $error("conversion ready latency");
  property p_self_lat; $fell(data_ready_n) && mode_r == MODE_SELF_CAL |-> cnt_r == 12 * P; endproperty
  a_self_lat: assert property (p_self_lat) else $error("self cal ready latency");
  property p_comb_lat; $fell(data_ready_n) && mode_r == MODE_OFS_IGAIN |-> cnt_r == 12 * P; endproperty
  a_comb_lat: assert property (p_comb_lat) else $error("combined cal ready latency");
  property p_sys_lat;
    $fell(data_ready_n) && mode_r inside {MODE_SYS_OFS, MODE_SYS_PFS, MODE_SYS_NFS} |-> cnt_r == 4 * P;
  endproperty
  a_sys_lat: assert property (p_sys_lat) else $error("system cal ready latency");
  property p_gain_lat; $fell(data_ready_n) && mode_r == MODE_SYS_GAIN |-> cnt_r == 9 * P; endproperty
  a_gain_lat: assert property (p_gain_lat) else $error("gain cal ready latency");
  property p_conv_keep;
    !data_ready_n && mode_r == MODE_CONVERT && !mode_write |=> $stable({ofs_coef, pfs_coef, nfs_coef});
  endproperty
  a_conv_keep: assert property (p_conv_keep) else $error("coefficient moved in conversion");
  property p_self_ofs; $changed(ofs_coef) && mode_r == MODE_SELF_CAL |-> cnt_r inside {[3*P:3*P+1]}; endproperty
  a_self_ofs: assert property (p_self_ofs) else $error("self cal offset update time");
  property p_self_pfs; $changed(pfs_coef) && mode_r == MODE_SELF_CAL |-> cnt_r inside {[6*P:6*P+1]}; endproperty
  a_self_pfs: assert property (p_self_pfs) else $error("self cal positive update time");
  property p_self_nfs; $changed(nfs_coef) && mode_r == MODE_SELF_CAL |-> cnt_r inside {[9*P:9*P+1]}; endproperty
  a_self_nfs: assert property (p_self_nfs) else $error("self cal negative update time");
  property p_gain_nfs; $changed(nfs_coef) && mode_r == MODE_SYS_GAIN |-> cnt_r inside {[4*P:4*P+1]}; endproperty
  a_gain_nfs: assert property (p_gain_nfs) else $error("gain cal negative update time");
  property p_gain_pfs; $changed(pfs_coef) && mode_r == MODE_SYS_GAIN |-> cnt_r inside {[8*P:8*P+1]}; endproperty
  a_gain_pfs: assert property (p_gain_pfs) else $error("gain cal positive update time");
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench: apb host controller facing the sequencer over the link
// assumes a shortened conversion period P; sample follows the analog routing
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cal_seq_pkg::*;
  localparam int P = 2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [23:0] sample_i = 24'h000000;
  logic [23:0] base = 24'h000000;
  logic [1:0] route;
  logic rev;
  logic rdy_d = 1'b1;
  logic [15:0] cnt = 16'h0000;
  logic [15:0] lat = 16'h0000;
  int n_fall = 0;
  int n_errors = 0;
  int cmp_count = 0;
  cal_seq_if link();
  always #4 clk_i = ~clk_i;
  cal_seq_device #(.CONV_PERIOD_CYCLES(P)) i_cal_seq_device (.clk_i(clk_i), .rst_i(rst_i),
    .link(link.device), .sample_i(sample_i), .route_o(route), .polarity_rev_o(rev));
  cal_seq_host i_cal_seq_host (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.host));
  cal_seq_sva #(.P(P)) i_cal_seq_sva (.clk_i(clk_i), .rst_i(rst_i),
    .op_mode_select(link.op_mode_select), .mode_write(link.mode_write),
    .data_ready_n(link.data_ready_n), .ofs_coef(link.ofs_coef), .pfs_coef(link.pfs_coef),
    .nfs_coef(link.nfs_coef));
  // ----------------------------------------------------------------
  // analog stand-in and ready latency monitor
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    sample_i <= base ^ {21'h000000, rev, route};
    // lat counts edges from the load edge to the edge that lowers ready
    cnt <= link.mode_write ? 16'h0000 : cnt + 16'h0001;
    rdy_d <= link.data_ready_n;
    if (rdy_d === 1'b1 && link.data_ready_n === 1'b0) begin
      lat <= cnt;
      n_fall <= n_fall + 1;
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
           output logic err);
    int i;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (pready !== 1'b1 && i < 100);
    if (i >= 100) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task run_mode(input op_mode_t m, input logic [2:0] g, input int exp_lat);
    logic [31:0] rd;
    logic err;
    int n0;
    int i;
    n0 = n_fall;
    apb(1'b1, REG_CTRL, {25'h0000000, g, 1'b0, m}, rd, err);
    chk({31'h00000000, err}, 32'h00000000);
    i = 0;
    while (n_fall == n0 && i < 2000) begin
      @(posedge clk_i);
      i++;
    end
    if (i >= 2000) n_errors++;
    chk({16'h0000, lat}, exp_lat[31:0]);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task s_reset_state;
    logic [31:0] rd;
    logic err;
    chk({31'h00000000, link.data_ready_n}, 32'h00000001);
    chk({8'h00, link.pfs_coef}, {8'h00, PFS_COEF_RST});
    apb(1'b0, 12'h020, 32'h00000000, rd, err);
    chk({31'h00000000, err}, 32'h00000001);
    apb(1'b1, REG_DATA, 32'h00000000, rd, err);
    chk({31'h00000000, err}, 32'h00000001);
  endtask
  task s_conv(input logic [23:0] b, input logic [23:0] ofs);
    base = b;
    run_mode(MODE_CONVERT, 3'h0, 3 * P);
    chk({8'h00, link.result_data}, {8'h00, b - ofs});
  endtask
  task s_sys;
    op_mode_t ms[3];
    logic [23:0] got;
    ms = '{MODE_SYS_OFS, MODE_SYS_PFS, MODE_SYS_NFS};
    for (int k = 0; k < 3; k++) begin
      base = 24'(24'h111111 * (k + 1));
      run_mode(ms[k], 3'h0, 4 * P);
      got = (k == 0) ? link.ofs_coef : (k == 1) ? link.pfs_coef : link.nfs_coef;
      chk({8'h00, got}, {8'h00, base});
    end
  endtask
  task s_refuse;
    logic [31:0] rd;
    logic err;
    apb(1'b1, REG_CTRL, {29'h00000000, MODE_RESERVED}, rd, err);
    chk({31'h00000000, err}, 32'h00000001);
    apb(1'b1, REG_CTRL, 32'h00000031, rd, err);
    chk({31'h00000000, err}, 32'h00000001);
    chk({31'h00000000, link.data_ready_n}, 32'h00000000);
    apb(1'b0, REG_STATUS, 32'h00000000, rd, err);
    chk(rd, 32'h00000003);
  endtask
  task s_abort;
    logic [31:0] rd;
    logic err;
    // the offset step is cut short two clock cycles before its store point
    apb(1'b1, REG_CTRL, {29'h00000000, MODE_SYS_OFS}, rd, err);
    repeat (3) @(posedge clk_i);
    s_conv(24'h0abcde, 24'h111111);
    chk({8'h00, link.ofs_coef}, 32'h00111111);
  endtask
  task s_cals;
    run_mode(MODE_SELF_CAL, 3'h0, 12 * P);
    run_mode(MODE_OFS_IGAIN, 3'h0, 12 * P);
    base = 24'h2468ac;
    run_mode(MODE_SYS_GAIN, 3'h0, 9 * P);
    chk({8'h00, link.nfs_coef}, 32'h002468ac);
    chk({8'h00, link.pfs_coef}, 32'h002468a8);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset_state;
    s_conv(24'h012345, 24'h000000);
    s_sys;
    s_conv(24'h543210, 24'h111111);
    s_refuse;
    s_abort;
    s_cals;
    complete_run;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
